// ---- core/ccmpe_defs.vh ----
// constants for the packet cipher engine
// Summary of operation
// - fresh keystream needed before each packet
// - keystream task starts generation, raises done
// - keystream stored in and read from scratch
// - default length mode: 27 byte keystream
// - extended mode: max size, capped 251
// - encrypt reads input, appends four byte check
// - cipher task in encrypt mode, then done
// - encrypt adds four to length, writes out
// - encrypt copies zero length packet unchanged
// - decrypt reads, verifies check, then done
// - decrypt subtracts four from length, writes
// - decrypt lengths one to four fail check
// - decrypt zero length passes unchanged, ok
// - length field width selectable by mode
// - data rate sampled at each task trigger
// - rate override task replaces active rate while a cipher run is active
// - no memory access after done events, except the shortcut cipher run after keystream done
// - header 0, length 1, reserved 2, payload 3
`ifndef CCMPE_DEFS_VH
`define CCMPE_DEFS_VH

`define CCMPE_KS_LEN_DEFAULT 8'h1B
`define CCMPE_KS_LEN_MAX 8'hFB
`define CCMPE_KS_LEN_MIN 8'h01
`define CCMPE_MIC_LEN 8'h04
`define CCMPE_MIC_LAST 2'h3
`define CCMPE_CFG_LEN 8'h19
`define CCMPE_KS_MIX 8'h1D
`define CCMPE_LEN_NARROW 8'h1F
`define CCMPE_OFS_HDR 32'h00000000
`define CCMPE_OFS_LEN 32'h00000001
`define CCMPE_OFS_RFU 32'h00000002
`define CCMPE_OFS_PAY 32'h00000003
`define CCMPE_FIFO_WIDTH 8
`define CCMPE_FIFO_DEPTH 32
`define CCMPE_FIFO_AW 5

`endif

// ---- core/ccmpe_engine.v ----
// packet cipher engine with its output fifo
`timescale 1ns/1ps
`include "ccmpe_defs.vh"

// ----------------------------------------
// output byte fifo
// ----------------------------------------
module ccmpe_fifo
#(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW = 5
)
(
	// clock and reset
	input wire core_clk,
	input wire rst_b,
	// fill side
	input wire inValid,
	input wire [WIDTH-1:0] inData,
	output wire inReady,
	// drain side
	output wire outValid,
	output wire [WIDTH-1:0] outData,
	input wire outReady
);
	localparam [AW:0] FULL = DEPTH[AW:0];
	localparam [AW-1:0] LAST = FULL[AW-1:0] - 1'b1;
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wp;
	reg [AW-1:0] rp;
	reg [AW:0] cnt;
	wire push;
	wire pop;

	assign inReady = (cnt != FULL);
	assign outValid = (cnt != {(AW+1){1'b0}});
	assign outData = mem[rp];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always @(posedge core_clk)
	begin
		if (push)
			mem[wp] <= inData;
	end

	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wp <= {AW{1'b0}};
			rp <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wp <= (wp == LAST) ? {AW{1'b0}} : wp + 1'b1;
			if (pop)
				rp <= (rp == LAST) ? {AW{1'b0}} : rp + 1'b1;
			if (push && !pop)
				cnt <= cnt + 1'b1;
			else if (pop && !push)
				cnt <= cnt - 1'b1;
		end
	end
endmodule

// ----------------------------------------
// engine
// ----------------------------------------
module ccmpe_engine
(
	// clock and reset
	input wire core_clk,
	input wire rst_b,
	// tasks
	input wire ksTask,
	input wire cipherTask,
	input wire rateOverrideTask,
	// configuration
	input wire shortcutEn,
	input wire modeDecrypt,
	input wire modeExtended,
	input wire lenWide,
	input wire [1:0] dataRate,
	input wire [1:0] rate_override_a,
	input wire [7:0] maxPayloadSize,
	// pointers
	input wire [31:0] configStructPointer,
	input wire [31:0] scratchAreaPointer,
	input wire [31:0] inputPacketPointer,
	input wire [31:0] outputPacketPointer,
	// events and status
	output reg ksDone,
	output reg cipherDone,
	output reg micOk,
	output reg busy,
	output reg [1:0] activeRate,
	// memory port
	output reg ramReq,
	output reg ramWrite,
	output reg [31:0] ramAddr,
	output reg [7:0] ramWdata,
	input wire [7:0] ramRdata,
	input wire ramAck
);
	localparam [3:0] S_IDLE = 4'h0;
	localparam [3:0] S_KSRD = 4'h1;
	localparam [3:0] S_KSWR = 4'h2;
	localparam [3:0] S_HDR = 4'h3;
	localparam [3:0] S_LEN = 4'h4;
	localparam [3:0] S_RFU = 4'h5;
	localparam [3:0] S_PIN = 4'h6;
	localparam [3:0] S_PKS = 4'h7;
	localparam [3:0] S_MICO = 4'h8;
	localparam [3:0] S_MICI = 4'h9;
	localparam [3:0] S_FLUSH = 4'hA;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [7:0] ksLenOf;
		input ext;
		input [7:0] maxSize;
		begin
			if (!ext)
				ksLenOf = `CCMPE_KS_LEN_DEFAULT;
			else if (maxSize > `CCMPE_KS_LEN_MAX)
				ksLenOf = `CCMPE_KS_LEN_MAX;
			else if (maxSize == 8'h00)
				ksLenOf = `CCMPE_KS_LEN_MIN;
			else
				ksLenOf = maxSize;
		end
	endfunction

	// stand-in for the block cipher, which is out of scope here
	function [7:0] mixByte;
		input [7:0] d;
		input [7:0] idx;
		begin
			mixByte = {d[6:0], d[7]} ^ (idx ^ `CCMPE_KS_MIX);
		end
	endfunction

	function [7:0] lenField;
		input [7:0] b;
		input wide;
		begin
			lenField = wide ? b : (b & `CCMPE_LEN_NARROW);
		end
	endfunction

	// narrow mode keeps the bits above the field untouched
	function [7:0] lenWrite;
		input [7:0] b;
		input wide;
		input [7:0] v;
		begin
			if (wide)
				lenWrite = v;
			else
				lenWrite = (b & ~`CCMPE_LEN_NARROW) | (v & `CCMPE_LEN_NARROW);
		end
	endfunction

	function [7:0] accByte;
		input [31:0] a;
		input [1:0] i;
		begin
			case (i)
				2'h0: accByte = a[31:24];
				2'h1: accByte = a[23:16];
				2'h2: accByte = a[15:8];
				default: accByte = a[7:0];
			endcase
		end
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [3:0] state;
	reg [7:0] ksLen;
	reg [7:0] ksIdx;
	reg [7:0] cfgIdx;
	reg [7:0] ksByte;
	reg [31:0] micSeed;
	reg [31:0] acc;
	reg [7:0] pinByte;
	reg [7:0] plen;
	reg [7:0] pIdx;
	reg [1:0] micIdx;
	reg micBad;
	reg micRes;
	reg isDec;
	reg isWide;
	reg emptyPkt;
	reg shortPkt;
	reg [8:0] wrIdx;
	reg needRead;
	reg [31:0] readAddr;
	reg pushValid;
	reg [7:0] pushData;

	wire fifoInReady;
	wire fifoOutValid;
	wire [7:0] fifoOutData;
	wire rdAck = ramReq && ramAck && !ramWrite;
	wire wrAck = ramReq && ramAck && ramWrite;
	// drain has priority so the fifo never blocks a read in flight
	wire drainGo = !ramReq && fifoOutValid;
	wire ksWrGo = !ramReq && (state == S_KSWR);
	wire readGo = !ramReq && !fifoOutValid && fifoInReady && needRead;
	wire [7:0] lenVal = lenField(ramRdata, isWide);
	wire [7:0] plainByte = isDec ? (pinByte ^ ramRdata) : pinByte;
	wire ksLast = (ksIdx == ksLen - 8'h01);
	wire ksFinish = wrAck && (state == S_KSWR) && ksLast;
	wire cipherActive = (state != S_IDLE) && (state != S_KSRD) && (state != S_KSWR);
	wire cipherGo = ((state == S_IDLE) && cipherTask && !ksTask) || (ksFinish && shortcutEn);
	wire [7:0] micOfs = plen + {6'h00, micIdx};
	reg [7:0] adjLen;

	always @*
	begin
		adjLen = lenVal;
		if (!isDec && lenVal != 8'h00)
			adjLen = lenVal + `CCMPE_MIC_LEN;
		else if (isDec && lenVal > `CCMPE_MIC_LEN)
			adjLen = lenVal - `CCMPE_MIC_LEN;
	end

	// ----------------------------------------
	// read address and fifo feed
	// ----------------------------------------
	always @*
	begin
		needRead = 1'b1;
		readAddr = inputPacketPointer;
		case (state)
			S_KSRD: readAddr = configStructPointer + {24'h0, cfgIdx};
			S_HDR: readAddr = inputPacketPointer + `CCMPE_OFS_HDR;
			S_LEN: readAddr = inputPacketPointer + `CCMPE_OFS_LEN;
			S_RFU: readAddr = inputPacketPointer + `CCMPE_OFS_RFU;
			S_PIN: readAddr = inputPacketPointer + `CCMPE_OFS_PAY + {24'h0, pIdx};
			S_PKS: readAddr = scratchAreaPointer + {24'h0, pIdx};
			S_MICI: readAddr = inputPacketPointer + `CCMPE_OFS_PAY + {24'h0, micOfs};
			default: needRead = 1'b0;
		endcase
	end

	always @*
	begin
		pushValid = 1'b0;
		pushData = ramRdata;
		case (state)
			S_HDR, S_RFU: pushValid = rdAck;
			S_LEN:
			begin
				pushValid = rdAck;
				pushData = lenWrite(ramRdata, isWide, adjLen);
			end
			S_PKS:
			begin
				pushValid = rdAck;
				pushData = pinByte ^ ramRdata;
			end
			S_MICO:
			begin
				pushValid = fifoInReady;
				pushData = accByte(acc, micIdx);
			end
			default: pushValid = 1'b0;
		endcase
	end

	ccmpe_fifo
	#(
		.WIDTH(`CCMPE_FIFO_WIDTH),
		.DEPTH(`CCMPE_FIFO_DEPTH),
		.AW(`CCMPE_FIFO_AW)
	)
	outFifo
	(
		.core_clk(core_clk),
		.rst_b(rst_b),
		.inValid(pushValid),
		.inData(pushData),
		.inReady(fifoInReady),
		.outValid(fifoOutValid),
		.outData(fifoOutData),
		.outReady(drainGo)
	);

	// ----------------------------------------
	// memory port and sequencing
	// ----------------------------------------
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= S_IDLE;
			ksLen <= `CCMPE_KS_LEN_DEFAULT;
			ksIdx <= 8'h00;
			cfgIdx <= 8'h00;
			ksByte <= 8'h00;
			micSeed <= 32'h00000000;
			acc <= 32'h00000000;
			pinByte <= 8'h00;
			plen <= 8'h00;
			pIdx <= 8'h00;
			micIdx <= 2'h0;
			micBad <= 1'b0;
			isDec <= 1'b0;
			isWide <= 1'b0;
			emptyPkt <= 1'b0;
			shortPkt <= 1'b0;
			wrIdx <= 9'h000;
			ksDone <= 1'b0;
			cipherDone <= 1'b0;
			micOk <= 1'b0;
			micRes <= 1'b0;
			busy <= 1'b0;
			activeRate <= 2'h0;
			ramReq <= 1'b0;
			ramWrite <= 1'b0;
			ramAddr <= 32'h00000000;
			ramWdata <= 8'h00;
		end
		else
		begin
			ksDone <= 1'b0;
			cipherDone <= 1'b0;
			if (rateOverrideTask && cipherActive)
				activeRate <= rate_override_a;
			if (ramReq && ramAck)
				ramReq <= 1'b0;
			else if (drainGo)
			begin
				ramReq <= 1'b1;
				ramWrite <= 1'b1;
				ramAddr <= outputPacketPointer + {23'h0, wrIdx};
				ramWdata <= fifoOutData;
				wrIdx <= wrIdx + 9'h001;
			end
			else if (ksWrGo)
			begin
				ramReq <= 1'b1;
				ramWrite <= 1'b1;
				ramAddr <= scratchAreaPointer + {24'h0, ksIdx};
				ramWdata <= ksByte;
			end
			else if (readGo)
			begin
				ramReq <= 1'b1;
				ramWrite <= 1'b0;
				ramAddr <= readAddr;
			end
			case (state)
				S_IDLE:
				begin
					if (ksTask)
					begin
						state <= S_KSRD;
						ksLen <= ksLenOf(modeExtended, maxPayloadSize);
						ksIdx <= 8'h00;
						cfgIdx <= 8'h00;
						micSeed <= 32'h00000000;
						busy <= 1'b1;
						activeRate <= dataRate;
					end
				end
				S_KSRD:
				begin
					if (rdAck)
					begin
						ksByte <= mixByte(ramRdata, ksIdx);
						micSeed <= {micSeed[23:0], micSeed[31:24] ^ ramRdata};
						if (cfgIdx == `CCMPE_CFG_LEN - 8'h01)
							cfgIdx <= 8'h00;
						else
							cfgIdx <= cfgIdx + 8'h01;
						state <= S_KSWR;
					end
				end
				S_KSWR:
				begin
					if (wrAck)
					begin
						ksIdx <= ksIdx + 8'h01;
						if (ksLast)
						begin
							ksDone <= 1'b1;
							busy <= 1'b0;
							state <= S_IDLE;
						end
						else
							state <= S_KSRD;
					end
				end
				S_HDR:
				begin
					if (rdAck)
						state <= S_LEN;
				end
				S_LEN:
				begin
					if (rdAck)
					begin
						emptyPkt <= (lenVal == 8'h00);
						shortPkt <= isDec && (lenVal != 8'h00) && (lenVal <= `CCMPE_MIC_LEN);
						plen <= adjLen;
						if (!isDec)
							plen <= lenVal;
						state <= S_RFU;
					end
				end
				S_RFU:
				begin
					if (rdAck)
					begin
						pIdx <= 8'h00;
						if (emptyPkt || shortPkt)
						begin
							if (isDec)
								micRes <= emptyPkt;
							state <= S_FLUSH;
						end
						else
							state <= S_PIN;
					end
				end
				S_PIN:
				begin
					if (rdAck)
					begin
						pinByte <= ramRdata;
						state <= S_PKS;
					end
				end
				S_PKS:
				begin
					if (rdAck)
					begin
						acc <= {acc[23:0], acc[31:24]} ^ {24'h000000, plainByte};
						pIdx <= pIdx + 8'h01;
						micIdx <= 2'h0;
						micBad <= 1'b0;
						if (pIdx != plen - 8'h01)
							state <= S_PIN;
						else if (isDec)
							state <= S_MICI;
						else
							state <= S_MICO;
					end
				end
				S_MICO:
				begin
					if (fifoInReady)
					begin
						micIdx <= micIdx + 2'h1;
						if (micIdx == `CCMPE_MIC_LAST)
							state <= S_FLUSH;
					end
				end
				S_MICI:
				begin
					if (rdAck)
					begin
						micIdx <= micIdx + 2'h1;
						micBad <= micBad || (ramRdata != accByte(acc, micIdx));
						if (micIdx == `CCMPE_MIC_LAST)
						begin
							micRes <= !(micBad || (ramRdata != accByte(acc, micIdx)));
							state <= S_FLUSH;
						end
					end
				end
				S_FLUSH:
				begin
					if (!ramReq && !fifoOutValid)
					begin
						cipherDone <= 1'b1;
						// status moves only with the done pulse, so it is never seen half-made
						if (isDec)
							micOk <= micRes;
						busy <= 1'b0;
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
			if (cipherGo)
			begin
				state <= S_HDR;
				busy <= 1'b1;
				isDec <= modeDecrypt;
				isWide <= lenWide;
				activeRate <= dataRate;
				acc <= micSeed;
				wrIdx <= 9'h000;
			end
		end
	end
endmodule

// ---- verif/ccmpe_engine_chk.sv ----
// port checks for the packet cipher engine
`timescale 1ns/1ps
module ccmpe_engine_chk
(
	// clock, reset, tasks, configuration
	input logic core_clk,
	input logic rst_b,
	input logic ksTask,
	input logic cipherTask,
	input logic shortcutEn,
	input logic [1:0] dataRate,
	// events and status
	input logic ksDone,
	input logic cipherDone,
	input logic micOk,
	input logic busy,
	input logic [1:0] activeRate,
	// memory port
	input logic ramReq,
	input logic ramWrite,
	input logic [31:0] ramAddr,
	input logic [7:0] ramWdata,
	input logic ramAck
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	sequence sWait;
		ramReq && !ramAck;
	endsequence
	sequence sXfer;
		ramReq && ramAck;
	endsequence
	sequence sTake;
		!busy && (ksTask || cipherTask);
	endsequence
	sequence sChain;
		ksDone && shortcutEn;
	endsequence
	a_req_held: assert property (sWait |=> ramReq && $stable(ramAddr) && $stable(ramWrite)
		&& (!ramWrite || $stable(ramWdata)))
		else $error("request changed before ack");
	a_req_release: assert property (sXfer |=> !ramReq)
		else $error("request kept after ack");
	a_task_taken: assert property (sTake |=> busy && activeRate == $past(dataRate))
		else $error("task not taken with its rate");
	a_ks_pulse: assert property (ksDone |=> !ksDone)
		else $error("keystream done too long");
	a_cipher_run_task_pulse: assert property (cipherDone |=> !cipherDone)
		else $error("cipher done too long");
	a_ks_quiet: assert property (ksDone && !shortcutEn |-> !busy && !ramReq)
		else $error("memory active at keystream done");
	a_cipher_run_task_quiet: assert property (cipherDone |-> !busy && !ramReq)
		else $error("memory active at cipher done");
	a_chain_start: assert property (sChain |-> busy ##[1:4] ramReq)
		else $error("shortcut did not start cipher");
	a_mic_steady: assert property (!cipherDone |-> $stable(micOk))
		else $error("check status moved without done");
endmodule

bind ccmpe_engine ccmpe_engine_chk ccmpe_engine_chk_inst(.core_clk(core_clk), .rst_b(rst_b),
	.ksTask(ksTask), .cipherTask(cipherTask), .shortcutEn(shortcutEn), .dataRate(dataRate),
	.ksDone(ksDone), .cipherDone(cipherDone), .micOk(micOk), .busy(busy),
	.activeRate(activeRate), .ramReq(ramReq), .ramWrite(ramWrite), .ramAddr(ramAddr),
	.ramWdata(ramWdata), .ramAck(ramAck));

// ---- verif/ccmpe_engine_tb.sv ----
// self-checking bench for the packet cipher engine
`timescale 1ns/1ps
module ccmpe_engine_tb;
	logic core_clk, rst_b, ksTask, cipherTask, rateOverrideTask, shortcutEn, modeDecrypt;
	logic modeExtended, lenWide, ramAck, ksDone, cipherDone, micOk, busy, ramReq, ramWrite;
	logic [1:0] dataRate, rate_override_a, activeRate, lat;
	logic [7:0] maxPayloadSize, ramRdata, ramWdata;
	logic [31:0] cfgP, scrP, inP, outP, ramAddr, winBase;
	int miscompares, comparisons, wrCount, k;
	ccmpe_engine ccmpe_engine_inst(.core_clk(core_clk), .rst_b(rst_b), .ksTask(ksTask),
		.cipherTask(cipherTask), .rateOverrideTask(rateOverrideTask), .shortcutEn(shortcutEn),
		.modeDecrypt(modeDecrypt), .modeExtended(modeExtended), .lenWide(lenWide),
		.dataRate(dataRate), .rate_override_a(rate_override_a), .maxPayloadSize(maxPayloadSize),
		.configStructPointer(cfgP), .scratchAreaPointer(scrP), .inputPacketPointer(inP),
		.outputPacketPointer(outP), .ksDone(ksDone), .cipherDone(cipherDone), .micOk(micOk),
		.busy(busy), .activeRate(activeRate), .ramReq(ramReq), .ramWrite(ramWrite),
		.ramAddr(ramAddr), .ramWdata(ramWdata), .ramRdata(ramRdata), .ramAck(ramAck));
	ccmpe_ram_model ccmpe_ram_model_inst(.core_clk(core_clk), .rst_b(rst_b), .lat(lat),
		.ramReq(ramReq), .ramWrite(ramWrite), .ramAddr(ramAddr), .ramWdata(ramWdata),
		.ramRdata(ramRdata), .ramAck(ramAck));
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// writes landing in the watched window
	always @(posedge core_clk)
		if (ramReq && ramAck && ramWrite && ramAddr - winBase < 32'h100)
			wrCount++;
	function logic [7:0] rd(input logic [11:0] a);
		return ccmpe_ram_model_inst.mem[a];
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task test_done();
		$display("miscompares %0d comparisons %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task waitDone(input logic sel);
		int n;
		for (n = 0; n < 3000; n++)
		begin
			@(posedge core_clk);
			#1;
			if (sel ? cipherDone : ksDone)
				break;
		end
		check(n < 3000, 32'h1);
	endtask
	task runKs();
		ksTask = 1'b1;
		@(posedge core_clk);
		#1;
		ksTask = 1'b0;
		waitDone(1'b0);
	endtask
	task runPkt(input logic dec);
		modeDecrypt = dec;
		runKs();
		winBase = outP;
		wrCount = 0;
		cipherTask = 1'b1;
		@(posedge core_clk);
		#1;
		cipherTask = 1'b0;
		waitDone(1'b1);
	endtask
	task putPkt(input logic [11:0] a, input logic [7:0] len);
		int i;
		ccmpe_ram_model_inst.mem[a] = 8'h5A;
		ccmpe_ram_model_inst.mem[a + 12'h1] = len;
		ccmpe_ram_model_inst.mem[a + 12'h2] = 8'h77;
		for (i = 0; i < len[4:0]; i++)
			ccmpe_ram_model_inst.mem[a + 12'h3 + i[11:0]] = 8'hC0 + i[7:0];
	endtask
	initial
	begin
		{ksTask, cipherTask, rateOverrideTask, shortcutEn, modeDecrypt, modeExtended} = 6'h00;
		{lenWide, dataRate, rate_override_a, maxPayloadSize, lat} = {1'b1, 4'h9, 8'h05, 2'h0};
		{cfgP, scrP, inP, outP, winBase} = {32'h0, 32'h300, 32'h100, 32'h200, 32'h300};
		{miscompares, comparisons, wrCount} = {32'h0, 32'h0, 32'h0};
		rst_b = 1'b0;
		for (k = 0; k < 25; k++)
			ccmpe_ram_model_inst.mem[k[11:0]] = 8'h10 + k[7:0];
		repeat (3) @(posedge core_clk);
		#1;
		rst_b = 1'b1;
		runKs();
		check(wrCount, 27);
		check(activeRate, 2'h2);
		modeExtended = 1'b1;
		wrCount = 0;
		runKs();
		check(wrCount, 5);
		{maxPayloadSize, lat, wrCount} = {8'hFF, 2'h2, 32'h0};
		runKs();
		check(wrCount, 251);
		modeExtended = 1'b0;
		putPkt(12'h100, 8'h03);
		runPkt(1'b0);
		check(wrCount, 10);
		check(rd(12'h200), 8'h5A);
		check(rd(12'h201), 8'h07);
		check(rd(12'h202), 8'h77);
		{inP, outP} = {32'h200, 32'h400};
		runPkt(1'b1);
		check(micOk, 1'b1);
		check(rd(12'h401), 8'h03);
		for (k = 0; k < 3; k++)
			check(rd(12'h403 + k[11:0]), 8'hC0 + k[7:0]);
		ccmpe_ram_model_inst.mem[12'h206] = ~rd(12'h206);
		runPkt(1'b1);
		check(micOk, 1'b0);
		{inP, outP} = {32'h500, 32'h600};
		for (k = 1; k < 5; k++)
		begin
			putPkt(12'h500, 8'h00);
			runPkt(1'b1);
			check(micOk, 1'b1);
			check(rd(12'h601), 8'h00);
			putPkt(12'h500, k[7:0]);
			runPkt(1'b1);
			check(micOk, 1'b0);
		end
		putPkt(12'h500, 8'h00);
		runPkt(1'b0);
		check(wrCount, 3);
		check(rd(12'h601), 8'h00);
		lenWide = 1'b0;
		putPkt(12'h500, 8'hE2);
		runPkt(1'b0);
		check(rd(12'h601), 8'hE6);
		lenWide = 1'b1;
		putPkt(12'h500, 8'h03);
		// pointers and shortcut set before keystream
		// output pointer stands for the radio buffer
		shortcutEn = 1'b1;
		runKs();
		check(busy, 1'b1);
		repeat (4) @(posedge core_clk);
		#1;
		rateOverrideTask = 1'b1;
		@(posedge core_clk);
		#1;
		rateOverrideTask = 1'b0;
		check(activeRate, 2'h1);
		waitDone(1'b1);
		check(rd(12'h601), 8'h07);
		shortcutEn = 1'b0;
		runKs();
		check(activeRate, 2'h2);
		test_done();
	end
	// the whole run needs well under twenty thousand cycles
	initial
	begin
		#400000;
		miscompares++;
		test_done();
	end
endmodule

// ---- verif/ccmpe_ram_model.sv ----
// shared byte memory answering the engine's memory port
`timescale 1ns/1ps
module ccmpe_ram_model
(
	// clock, reset, latency
	input logic core_clk,
	input logic rst_b,
	input logic [1:0] lat,
	// memory port
	input logic ramReq,
	input logic ramWrite,
	input logic [31:0] ramAddr,
	input logic [7:0] ramWdata,
	output logic [7:0] ramRdata,
	output logic ramAck
);
	logic [7:0] mem [0:4095];
	logic [1:0] waitCnt;
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ramAck <= 1'b0;
			waitCnt <= 2'h0;
			ramRdata <= 8'hA5;
		end
		else
		begin
			ramAck <= 1'b0;
			// idle data toggles so a stale byte never looks valid
			ramRdata <= ~ramRdata;
			if (ramReq && !ramAck && waitCnt >= lat)
			begin
				ramAck <= 1'b1;
				waitCnt <= 2'h0;
				if (ramWrite)
					mem[ramAddr[11:0]] <= ramWdata;
				else
					ramRdata <= mem[ramAddr[11:0]];
			end
			else if (ramReq && !ramAck)
				waitCnt <= waitCnt + 2'h1;
		end
	end
endmodule
